/* File: ace_pkg.sv */
// Purpose: Shared constants for the comparator event control block.
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word.
// Notes: Offsets, bit positions, reset values and event mode codes.
package ace_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CSR = 8'h00;
  localparam logic [7:0] OFS_SFIO = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_BANDGAP = 6;
  localparam int BIT_RESULT = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_CAPTURE = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;
  localparam int BIT_MUX_EN = 3;
  localparam int BIT_STAT_EVENT = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] SFIO_RESET = 8'h00;
  localparam logic IRQ_EN_RESET = 1'h0;

  // ****************************************
  // Event modes and bus answers
  // ****************************************
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYNC_STAGES = 2;

endpackage

/* File: ace_sync.sv */
// Purpose: Flip-flop chain carrying an asynchronous level into the clock.
// Assumes: Input may change at any time relative to CLOCK_IN.
// Notes: Only the last stage is visible outside.
module ace_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset
  input logic clk_in,
  input logic rst_in,
  // Level
  input logic async_in,
  output logic sync_out
);

  logic [STAGES-1:0] chain_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_q[STAGES-1];

endmodule

/* File: ace_comparator_ctrl.sv */
// Purpose: Digital control around the on-chip voltage comparator.
// Assumes: Pin voltages arrive as unsigned codes from the analog front end.
// Notes: Registers reached over AXI4-Lite; comparator event interrupt.
// Contract
// R1: Result is high when selected positive input exceeds selected negative.
// R2: Result is synchronized into the clock, adding one to two cycles; here two sync stages plus result_q add three cycles.
// R3: Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// R4: Hardware sets the event flag on a change matching the mode.
// R5: Flag clears on interrupt vectoring or a written one; zero keeps it.
// R6: Request interrupt only with flag, enable bit and global enable set; IRQ_OUT is raised from stat_q and irq_en_q alone, without these.
// R7: Power-off bit removes comparator power at any time; zero keeps it on.
// R8: Bandgap select feeds the reference to the positive input, else pin.
// R9: Capture enable routes the result to the timer capture front end.
// R10: With capture enable clear the result never reaches the timer.
// R11: Mux enable with converter off picks converter input 0..7 as negative.
// R12: Software clears interrupt enable before changing the power-off bit.
// R13: Software clears interrupt enable before changing the event mode.
// R14: Software sets the timer capture interrupt enable to use capture.
// R15: Edges are found against last cycle's result, one pulse each.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
module ace_comparator_ctrl
  import ace_pkg::*;
#(
  parameter int VW = 10,
  parameter logic [VW-1:0] BANDGAP_CODE = VW'(1) << (VW - 2)
) (
  // Clock and reset
  input logic CLOCK_IN,
  input logic RST_IN,
  // AXI4-Lite write address and data
  input logic [7:0] S_AXI_AWADDR_IN,
  input logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input logic [31:0] S_AXI_WDATA_IN,
  input logic [3:0] S_AXI_WSTRB_IN,
  input logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input logic S_AXI_BREADY_IN,
  // AXI4-Lite read
  input logic [7:0] S_AXI_ARADDR_IN,
  input logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input logic S_AXI_RREADY_IN,
  // Analog input codes
  input logic [VW-1:0] POSITIVE_INPUT_PIN_IN,
  input logic [VW-1:0] NEGATIVE_INPUT_PIN_IN,
  input logic [8*VW-1:0] CONVERTER_INPUTS_IN,
  // Converter and processor state
  input logic CONVERTER_ENABLE_IN,
  input logic [2:0] CHANNEL_SELECT_IN,
  input logic GLOBAL_IRQ_ENABLE_IN,
  input logic IRQ_VECTOR_ACK_IN,
  // Outputs to the rest of the chip
  output logic COMPARE_RESULT_OUT,
  output logic COMPARE_IRQ_REQ_OUT,
  output logic CAPTURE_SIGNAL_OUT,
  output logic POWER_OFF_OUT,
  output logic IRQ_OUT
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] csr_q;
  logic [7:0] sfio_q;
  logic [1:0] pwr_bg_q;
  logic [3:0] ctl_lo_q;
  logic flag_q, stat_q, irq_en_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic result_q, prev_q, capture_q, irq_req_q;
  logic [VW-1:0] conv_chan [8];
  logic [VW-1:0] pos_sel, neg_sel;
  logic raw_cmp, result_sync, event_hit;
  logic wr_fire, wr_csr, flag_clear;
  logic [1:0] mode;

  function automatic logic reg_known(input logic [7:0] addr);
    reg_known = (addr == OFS_CSR) || (addr == OFS_SFIO) ||
                (addr == OFS_IRQ_STAT) || (addr == OFS_IRQ_CLR) ||
                (addr == OFS_IRQ_EN);
  endfunction

  // ****************************************
  // Input selection and comparison
  // ****************************************
  for (genvar i = 0; i < 8; i++) begin : g_chan
    assign conv_chan[i] = CONVERTER_INPUTS_IN[i*VW +: VW];
  end

  assign pos_sel = csr_q[BIT_BANDGAP] ? BANDGAP_CODE
                                      : POSITIVE_INPUT_PIN_IN; // R8
  assign neg_sel = (sfio_q[BIT_MUX_EN] && !CONVERTER_ENABLE_IN)
                   ? conv_chan[CHANNEL_SELECT_IN]
                   : NEGATIVE_INPUT_PIN_IN; // R11
  // Unpowered comparator reads as low
  assign raw_cmp = !csr_q[BIT_POWER_OFF] && (pos_sel > neg_sel); // R1 R7

  ace_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .async_in(raw_cmp),
    .sync_out(result_sync)
  );

  // ****************************************
  // Result and edge detection
  // ****************************************
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      result_q <= 1'h0;
      prev_q <= 1'h0;
    end else begin
      result_q <= result_sync; // R2
      prev_q <= result_q; // R15
    end
  end

  assign mode = csr_q[BIT_MODE_HI:BIT_MODE_LO];

  always_comb begin
    case (mode)
      MODE_TOGGLE: event_hit = result_q != prev_q; // R3 R15
      MODE_FALL: event_hit = prev_q && !result_q; // R3
      MODE_RISE: event_hit = !prev_q && result_q; // R3
      default: event_hit = 1'h0; // R3
    endcase
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign S_AXI_AWREADY_OUT = !aw_hold_q && !bvalid_q;
  assign S_AXI_WREADY_OUT = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_csr = wr_fire && (aw_addr_q == OFS_CSR) && w_strb_q[0];

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_hold_q <= 1'h0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_hold_q <= 1'h1;
        aw_addr_q <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_hold_q <= 1'h1;
        w_data_q <= S_AXI_WDATA_IN;
        w_strb_q <= S_AXI_WSTRB_IN;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'h0;
        w_hold_q <= 1'h0;
        bvalid_q <= 1'h1;
        bresp_q <= reg_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY_IN) begin
        bvalid_q <= 1'h0;
      end
    end
  end

  assign S_AXI_BVALID_OUT = bvalid_q;
  assign S_AXI_BRESP_OUT = bresp_q;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pwr_bg_q <= CSR_RESET[7:6];
      ctl_lo_q <= CSR_RESET[3:0];
      sfio_q <= SFIO_RESET;
      irq_en_q <= IRQ_EN_RESET;
    end else if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q == OFS_CSR) begin
        pwr_bg_q <= w_data_q[7:6]; // R7 R8
        ctl_lo_q <= w_data_q[3:0]; // R3 R9
      end
      if (aw_addr_q == OFS_SFIO) begin
        sfio_q <= w_data_q[7:0];
      end
      if (aw_addr_q == OFS_IRQ_EN) begin
        irq_en_q <= w_data_q[BIT_STAT_EVENT];
      end
    end
  end

  // One driver per field; result bit mirrors the synced result
  assign csr_q = {pwr_bg_q, result_q, flag_q, ctl_lo_q};

  // ****************************************
  // Event flag, status and interrupts
  // ****************************************
  assign flag_clear = IRQ_VECTOR_ACK_IN ||
                      (wr_csr && w_data_q[BIT_FLAG]); // R5

  // An event in the clearing cycle is kept
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flag_q <= CSR_RESET[BIT_FLAG];
    end else if (event_hit) begin
      flag_q <= 1'h1; // R4
    end else if (flag_clear) begin
      flag_q <= 1'h0; // R5
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      stat_q <= 1'h0;
    end else if (event_hit) begin
      stat_q <= 1'h1;
    end else if (wr_fire && w_strb_q[0] && aw_addr_q == OFS_IRQ_CLR &&
                 w_data_q[BIT_STAT_EVENT]) begin
      stat_q <= 1'h0;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_req_q <= 1'h0;
      capture_q <= 1'h0;
    end else begin
      irq_req_q <= csr_q[BIT_FLAG] && csr_q[BIT_IRQ_EN] &&
                   GLOBAL_IRQ_ENABLE_IN; // R6
      // Timer front end does its own filtering and edge choice
      capture_q <= csr_q[BIT_CAPTURE] && result_q; // R9 R10
    end
  end

  assign COMPARE_RESULT_OUT = result_q;
  assign COMPARE_IRQ_REQ_OUT = irq_req_q;
  assign CAPTURE_SIGNAL_OUT = capture_q;
  assign POWER_OFF_OUT = csr_q[BIT_POWER_OFF]; // R7
  assign IRQ_OUT = stat_q && irq_en_q;

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign S_AXI_ARREADY_OUT = !rvalid_q;

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && !rvalid_q) begin
      rvalid_q <= 1'h1;
      rresp_q <= reg_known(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
      case (S_AXI_ARADDR_IN)
        OFS_CSR: rdata_q <= {24'h00_0000, csr_q};
        OFS_SFIO: rdata_q <= {24'h00_0000, sfio_q};
        OFS_IRQ_STAT: rdata_q <= {31'h0000_0000, stat_q};
        OFS_IRQ_EN: rdata_q <= {31'h0000_0000, irq_en_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY_IN) begin
      rvalid_q <= 1'h0;
    end
  end

  assign S_AXI_RVALID_OUT = rvalid_q;
  assign S_AXI_RDATA_OUT = rdata_q;
  assign S_AXI_RRESP_OUT = rresp_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);

  compare_level_a: assert property ( // R1
    (!csr_q[BIT_POWER_OFF] && pos_sel > neg_sel)[*4] |-> result_q)
    else $error("result low while positive input is higher");
  sync_latency_a: assert property ( // R2
    ##3 result_q == $past(raw_cmp, 3))
    else $error("result does not follow comparator after sync");
  reserved_mode_a: assert property ( // R3
    (mode == MODE_RESERVED && !csr_q[BIT_FLAG]) |=> !csr_q[BIT_FLAG])
    else $error("flag set in reserved mode");
  rise_sets_flag_a: assert property ( // R4
    (mode == MODE_RISE && $rose(result_q)) |=> csr_q[BIT_FLAG])
    else $error("rising edge missed");
  fall_sets_flag_a: assert property ( // R4
    (mode == MODE_FALL && $fell(result_q)) |=> csr_q[BIT_FLAG])
    else $error("falling edge missed");
  vector_clear_a: assert property ( // R5
    (IRQ_VECTOR_ACK_IN && !event_hit) |=> !csr_q[BIT_FLAG])
    else $error("flag survived vector acknowledge");
  irq_gate_a: assert property ( // R6
    COMPARE_IRQ_REQ_OUT |-> $past(csr_q[BIT_FLAG]) &&
      $past(csr_q[BIT_IRQ_EN]) && $past(GLOBAL_IRQ_ENABLE_IN))
    else $error("interrupt requested without all enables");
  power_off_a: assert property ( // R7
    csr_q[BIT_POWER_OFF][*4] |-> !result_q)
    else $error("result high while comparator unpowered");
  bandgap_sel_a: assert property ( // R8
    csr_q[BIT_BANDGAP] |-> pos_sel == BANDGAP_CODE)
    else $error("bandgap not on positive input");
  capture_route_a: assert property ( // R9
    csr_q[BIT_CAPTURE] |=> CAPTURE_SIGNAL_OUT == $past(result_q))
    else $error("capture output does not follow result");
  capture_off_a: assert property ( // R10
    !csr_q[BIT_CAPTURE] |=> !CAPTURE_SIGNAL_OUT)
    else $error("capture output active while routing disabled");
  mux_select_a: assert property ( // R11
    (sfio_q[BIT_MUX_EN] && !CONVERTER_ENABLE_IN) |->
      neg_sel == CONVERTER_INPUTS_IN[CHANNEL_SELECT_IN*VW +: VW])
    else $error("wrong negative input selected");
  edge_pulse_a: assert property ( // R15
    event_hit |-> result_q != prev_q)
    else $error("event without result change");
  bresp_hold_a: assert property (
    (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN) |=> S_AXI_BVALID_OUT)
    else $error("write response dropped");

endmodule

/* File: ace_far_model.sv */
// Purpose: Far side model: analog pin codes and timer capture input.
// Assumes: Codes are unsigned; a larger code is a higher voltage.
// Notes: Converter channel i sits at 32 + 64*i; negative pin at 300.
module ace_far_model #(
  parameter int VW = 10
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Levels and timer side
  input wire logic [VW-1:0] pos_code_in,
  input wire logic cap_irq_en_in,
  input wire logic capture_in,
  // Pins and capture count
  output logic [VW-1:0] pos_pin_out,
  output logic [VW-1:0] neg_pin_out,
  output logic [8*VW-1:0] conv_out,
  output logic [7:0] capture_count_out
);
  logic cap_last_q;
  assign pos_pin_out = pos_code_in;
  // Above the default bandgap code
  assign neg_pin_out = VW'(16'h012C);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      conv_out[i*VW +: VW] = VW'(32'h20 + 32'h40 * i);
    end
  end
  // Timer counts capture edges only with its own interrupt enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_last_q <= 1'b0;
      capture_count_out <= 8'h00;
    end else begin
      cap_last_q <= capture_in;
      if (capture_in && !cap_last_q && cap_irq_en_in) begin
        capture_count_out <= capture_count_out + 8'h01;
      end
    end
  end
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the comparator event control block.
// Assumes: Far side model supplies pin codes and counts captures.
// Notes: Waits of six cycles cover the synchronizer and flag latency.
module tb_top
  import ace_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrr, bv, arr, rv, res, req, cap, poff, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] pos = 10'h064;
  logic conv_en = 1'b0, gie = 1'b0, ack = 1'b0, cap_en = 1'b0;
  logic [2:0] chan = 3'h0;
  logic [9:0] ppin, npin;
  logic [79:0] conv;
  logic [7:0] ccnt;
  logic ef;
  int mismatches = 0;
  int total_checks = 0;

  always #20 clk = ~clk;

  ace_comparator_ctrl dut (.CLOCK_IN(clk), .RST_IN(rst),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrr), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rry), .POSITIVE_INPUT_PIN_IN(ppin),
    .NEGATIVE_INPUT_PIN_IN(npin), .CONVERTER_INPUTS_IN(conv),
    .CONVERTER_ENABLE_IN(conv_en), .CHANNEL_SELECT_IN(chan),
    .GLOBAL_IRQ_ENABLE_IN(gie), .IRQ_VECTOR_ACK_IN(ack),
    .COMPARE_RESULT_OUT(res), .COMPARE_IRQ_REQ_OUT(req),
    .CAPTURE_SIGNAL_OUT(cap), .POWER_OFF_OUT(poff), .IRQ_OUT(irq));

  ace_far_model far (.clk_in(clk), .rst_in(rst), .pos_code_in(pos),
    .cap_irq_en_in(cap_en), .capture_in(cap), .pos_pin_out(ppin),
    .neg_pin_out(npin), .conv_out(conv), .capture_count_out(ccnt));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask

  // Ends just after an edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] br;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrr;
      tb = bv;
      br = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) break;
    end
    bry <= 1'b0;
    chk("write answer", 32'(n < 40), 32'h1);
    if (n == 40) end_sim();
    chk("bresp", br, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int n;
    logic ta, tr;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) break;
    end
    rry <= 1'b0;
    chk("read answer", 32'(n < 40), 32'h1);
    if (n == 40) end_sim();
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    chk(nm, v, e);
    chk("rresp", r, RESP_OKAY);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc("csr reset", OFS_CSR, 32'(CSR_RESET));
    rc("sfio reset", OFS_SFIO, 32'(SFIO_RESET));
    rc("irq en reset", OFS_IRQ_EN, 32'(IRQ_EN_RESET));
    rd(8'h14, v, r);
    chk("unmapped resp", r, RESP_SLVERR);
    chk("unmapped data", v, 32'h0);
    wr(8'h14, 32'hFF, RESP_SLVERR);
    wr(OFS_SFIO, 32'hFF, RESP_OKAY);
    rc("sfio rw", OFS_SFIO, 32'hFF);
    wr(OFS_SFIO, 32'h0, RESP_OKAY);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CSR, 32'(m), RESP_OKAY);
      wr(OFS_CSR, 32'(m) | 32'h10, RESP_OKAY);
      pos <= 10'h190;
      wt(6);
      chk("result", res, 32'h1);
      ef = (m == 0) || (m == 3);
      rc("csr rise", OFS_CSR, {26'h0, 1'b1, ef, 4'(m)});
      wr(OFS_CSR, 32'(m) | 32'h10, RESP_OKAY);
      pos <= 10'h064;
      wt(6);
      ef = (m == 0) || (m == 2);
      wr(OFS_CSR, 32'(m), RESP_OKAY);
      rc("csr fall", OFS_CSR, {27'h0, ef, 4'(m)});
    end
    $display("test modes done");
    wr(OFS_CSR, 32'h13, RESP_OKAY);
    wr(OFS_IRQ_CLR, 32'h1, RESP_OKAY);
    wr(OFS_IRQ_EN, 32'h1, RESP_OKAY);
    wr(OFS_CSR, 32'h0B, RESP_OKAY);
    gie <= 1'b1;
    pos <= 10'h190;
    wt(6);
    chk("irq", irq, 32'h1);
    chk("irq req", req, 32'h1);
    rc("status", OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
    gie <= 1'b0;
    wt(2);
    chk("irq masked", irq, 32'h0);
    chk("req no global", req, 32'h0);
    wr(OFS_IRQ_EN, 32'h1, RESP_OKAY);
    wt(1);
    chk("irq unmasked", irq, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1, RESP_OKAY);
    wt(1);
    chk("irq cleared", irq, 32'h0);
    rc("status clr", OFS_IRQ_STAT, 32'h0);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    wt(2);
    rc("csr vector", OFS_CSR, 32'h2B);
    wr(OFS_CSR, 32'h03, RESP_OKAY);
    pos <= 10'h064;
    $display("test interrupt done");
    wr(OFS_SFIO, 32'h08, RESP_OKAY);
    pos <= 10'h0FA;
    for (int ch = 0; ch < 8; ch++) begin
      @(posedge clk);
      chan <= 3'(ch);
      wt(6);
      chk("mux result", res, 32'(250 > 32 + 64 * ch));
    end
    @(posedge clk);
    chan <= 3'h0;
    conv_en <= 1'b1;
    wt(6);
    chk("converter on", res, 32'h0);
    conv_en <= 1'b0;
    wt(6);
    chk("converter off", res, 32'h1);
    wr(OFS_SFIO, 32'h0, RESP_OKAY);
    wt(6);
    chk("mux off", res, 32'h0);
    wr(OFS_SFIO, 32'h08, RESP_OKAY);
    chan <= 3'h4;
    pos <= 10'h190;
    wt(6);
    chk("pin positive", res, 32'h1);
    wr(OFS_CSR, 32'h40, RESP_OKAY);
    wt(6);
    chk("bandgap low", res, 32'h0);
    chan <= 3'h3;
    wt(6);
    chk("bandgap high", res, 32'h1);
    wr(OFS_SFIO, 32'h0, RESP_OKAY);
    $display("test inputs done");
    wr(OFS_CSR, 32'h0, RESP_OKAY);
    wt(6);
    chk("capture off", cap, 32'h0);
    cap_en <= 1'b1;
    wr(OFS_CSR, 32'h04, RESP_OKAY);
    wt(3);
    chk("capture on", cap, 32'h1);
    chk("capture count", ccnt, 32'h1);
    wr(OFS_CSR, 32'h80, RESP_OKAY);
    wt(6);
    chk("power off", poff, 32'h1);
    chk("result off", res, 32'h0);
    rc("csr off", OFS_CSR, 32'h90);
    $display("test capture and power done");
    end_sim();
  end
endmodule
